// *** hw/wdtc_counter.sv ***
module wdtc_counter #(
   parameter int WIDTH = wdtc_pkg::CNT_WIDTH
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic tick_in,
   input wire logic run_in,
   input wire logic clear_in,
   input wire logic [2:0] isel_in,
   output logic [WIDTH-1:0] count_out,
   output logic timeout_out
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic timeout;
   } wdtc_count_s;

   wdtc_count_s state_reg;
   wdtc_count_s state_next;
   logic [WIDTH-1:0] mask;

   always_comb begin
      mask = WIDTH'(wdtc_pkg::interval_mask(isel_in));
      state_next = state_reg;
      state_next.timeout = 1'b0;
      if (clear_in) begin
         state_next.count = '0;
      end else if (run_in && tick_in) begin
         // Free running: every interval boundary raises a timeout
         state_next.count = state_reg.count + WIDTH'(1);
         state_next.timeout = ((state_reg.count & mask) == mask);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign count_out = state_reg.count;
   assign timeout_out = state_reg.timeout;

endmodule

// *** hw/wdtc_pkg.sv ***
package wdtc_pkg;

   localparam int CNT_WIDTH = 18;
   localparam int ADDR_WIDTH = 8;

   // Register map, byte addresses
   localparam logic [7:0] CTRL_STATUS_OFFSET = 8'h00;
   localparam logic [31:0] CTRL_STATUS_RESET = 32'h0000_0700;

   // Field positions of watchdog_control_status
   localparam int DEBUG_ACK_IGNORE_BIT = 31;
   localparam int INTERVAL_SELECT_LSB = 8;
   localparam int ENABLE_BIT = 7;
   localparam int IRQ_ENABLE_BIT = 6;
   localparam int WAKEUP_FLAG_BIT = 5;
   localparam int WAKEUP_ENABLE_BIT = 4;
   localparam int IRQ_FLAG_BIT = 3;
   localparam int RESET_FLAG_BIT = 2;
   localparam int RESET_ENABLE_BIT = 1;
   localparam int CLEAR_BIT = 0;
   localparam logic [2:0] INTERVAL_SELECT_RESET = 3'h7;

   // Unlock byte sequence
   localparam logic [7:0] UNLOCK_BYTE_1 = 8'h59;
   localparam logic [7:0] UNLOCK_BYTE_2 = 8'h16;
   localparam logic [7:0] UNLOCK_BYTE_3 = 8'h88;

   // Timing in watchdog clocks
   localparam int INTERVAL_BASE_EXP = 4;
   localparam int RESET_DELAY_TICKS = 1024;
   localparam int RESET_HOLD_TICKS = 63;

   // Low bits that must all be ones on the tick that ends an interval
   function automatic logic [CNT_WIDTH-1:0] interval_mask(input logic [2:0] sel);
      logic [CNT_WIDTH:0] one_hot;
      one_hot = (CNT_WIDTH+1)'(1) << (INTERVAL_BASE_EXP + 2 * int'(sel));
      return CNT_WIDTH'(one_hot - (CNT_WIDTH+1)'(1));
   endfunction

endpackage

// *** hw/wdtc_top.sv ***
module wdtc_top (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [wdtc_pkg::ADDR_WIDTH-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic watchdog_clock_in,
   input wire logic debugger_ack_in,
   input wire logic low_speed_rc_osc_sel_in,
   input wire logic power_down_in,
   input wire logic register_unlock_port_wr_in,
   input wire logic [7:0] register_unlock_port_data_in,
   output logic timeout_irq_out,
   output logic wakeup_req_out,
   output logic chip_reset_out
);

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic debug_ack_ignore;
      logic [2:0] interval_select;
      logic watchdog_enable_bit;
      logic timeout_irq_enable;
      logic wakeup_flag;
      logic wakeup_enable;
      logic timeout_irq_flag;
      logic chip_reset_flag;
      logic chip_reset_enable;
      logic counter_clear;
      logic dly_act;
      logic [9:0] dly_cnt;
      logic [5:0] hold_cnt;
      logic chip_reset;
      logic irq;
      logic wake;
      logic wclk_prev;
   } wdtc_state_s;

   wdtc_state_s state_reg;
   wdtc_state_s state_next;

   logic unlocked;
   logic tick;
   logic run;
   logic timeout;
   logic [wdtc_pkg::CNT_WIDTH-1:0] count;
   logic bus_req;
   logic hit;
   logic wr;
   logic dly_expire;

   localparam logic [9:0] DLY_LAST = 10'(wdtc_pkg::RESET_DELAY_TICKS - 1);
   localparam logic [5:0] HOLD_INIT = 6'(wdtc_pkg::RESET_HOLD_TICKS);

   wdtc_unlock u_unlock (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .unlock_wr_in(register_unlock_port_wr_in),
      .unlock_data_in(register_unlock_port_data_in),
      .unlocked_out(unlocked)
   );

   wdtc_counter #(
      .WIDTH(wdtc_pkg::CNT_WIDTH)
   ) u_counter (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .tick_in(tick),
      .run_in(run),
      .clear_in(state_reg.counter_clear || !state_reg.watchdog_enable_bit),
      .isel_in(state_reg.interval_select),
      .count_out(count),
      .timeout_out(timeout)
   );

   // Watchdog clock is sampled here; one tick per rising edge
   assign tick = watchdog_clock_in && !state_reg.wclk_prev;
   assign run = state_reg.watchdog_enable_bit
      && (state_reg.debug_ack_ignore || !debugger_ack_in);
   assign bus_req = wb_cyc_in && wb_stb_in && !state_reg.ack;
   assign hit = (wb_adr_in == wdtc_pkg::CTRL_STATUS_OFFSET);
   assign wr = bus_req && wb_we_in && hit;
   assign dly_expire = state_reg.dly_act && run && tick && (state_reg.dly_cnt == DLY_LAST);

   always_comb begin
      state_next = state_reg;
      state_next.wclk_prev = watchdog_clock_in;
      state_next.ack = bus_req;
      state_next.wake = 1'b0;
      state_next.counter_clear = 1'b0;

      // Protected fields: only while unlocked
      if (wr && unlocked) begin
         if (wb_sel_in[3]) begin
            state_next.debug_ack_ignore = wb_dat_in[wdtc_pkg::DEBUG_ACK_IGNORE_BIT];
         end
         if (wb_sel_in[1]) begin
            state_next.interval_select = wb_dat_in[wdtc_pkg::INTERVAL_SELECT_LSB +: 3];
         end
         if (wb_sel_in[0]) begin
            state_next.watchdog_enable_bit = wb_dat_in[wdtc_pkg::ENABLE_BIT];
            state_next.timeout_irq_enable = wb_dat_in[wdtc_pkg::IRQ_ENABLE_BIT];
            state_next.wakeup_enable = wb_dat_in[wdtc_pkg::WAKEUP_ENABLE_BIT];
            state_next.chip_reset_enable = wb_dat_in[wdtc_pkg::RESET_ENABLE_BIT];
            state_next.counter_clear = wb_dat_in[wdtc_pkg::CLEAR_BIT];
         end
      end

      // Flags clear on write 1 without unlocking; hardware set below wins
      if (wr && wb_sel_in[0]) begin
         if (wb_dat_in[wdtc_pkg::WAKEUP_FLAG_BIT]) state_next.wakeup_flag = 1'b0;
         if (wb_dat_in[wdtc_pkg::IRQ_FLAG_BIT]) state_next.timeout_irq_flag = 1'b0;
         if (wb_dat_in[wdtc_pkg::RESET_FLAG_BIT]) state_next.chip_reset_flag = 1'b0;
      end

      // Post-timeout delay; a clear or a disable cancels it
      if (state_reg.counter_clear || !state_reg.watchdog_enable_bit) begin
         state_next.dly_act = 1'b0;
         state_next.dly_cnt = '0;
      end else if (timeout) begin
         if (state_reg.timeout_irq_enable) state_next.timeout_irq_flag = 1'b1;
         if (!state_reg.dly_act) begin
            state_next.dly_act = 1'b1;
            state_next.dly_cnt = '0;
         end
         if (state_reg.wakeup_enable && power_down_in && low_speed_rc_osc_sel_in) begin
            state_next.wake = 1'b1;
            state_next.wakeup_flag = 1'b1;
         end
      end else if (dly_expire) begin
         state_next.dly_act = 1'b0;
         state_next.dly_cnt = '0;
         if (state_reg.chip_reset_enable && !state_reg.chip_reset) begin
            state_next.chip_reset = 1'b1;
            state_next.hold_cnt = HOLD_INIT;
            state_next.chip_reset_flag = 1'b1;
         end
      end else if (state_reg.dly_act && run && tick) begin
         state_next.dly_cnt = state_reg.dly_cnt + 10'h001;
      end

      // Reset hold counts watchdog clocks whether or not the counter runs
      if (state_reg.chip_reset && tick) begin
         state_next.hold_cnt = state_reg.hold_cnt - 6'h01;
         if (state_reg.hold_cnt == 6'h01) state_next.chip_reset = 1'b0;
      end

      state_next.irq = state_next.timeout_irq_flag && state_next.timeout_irq_enable;

      state_next.rdat = '0;
      if (bus_req && !wb_we_in && hit) begin
         state_next.rdat[wdtc_pkg::DEBUG_ACK_IGNORE_BIT] = state_reg.debug_ack_ignore;
         state_next.rdat[wdtc_pkg::INTERVAL_SELECT_LSB +: 3] = state_reg.interval_select;
         state_next.rdat[wdtc_pkg::ENABLE_BIT] = state_reg.watchdog_enable_bit;
         state_next.rdat[wdtc_pkg::IRQ_ENABLE_BIT] = state_reg.timeout_irq_enable;
         state_next.rdat[wdtc_pkg::WAKEUP_FLAG_BIT] = state_reg.wakeup_flag;
         state_next.rdat[wdtc_pkg::WAKEUP_ENABLE_BIT] = state_reg.wakeup_enable;
         state_next.rdat[wdtc_pkg::IRQ_FLAG_BIT] = state_reg.timeout_irq_flag;
         state_next.rdat[wdtc_pkg::RESET_FLAG_BIT] = state_reg.chip_reset_flag;
         state_next.rdat[wdtc_pkg::RESET_ENABLE_BIT] = state_reg.chip_reset_enable;
         state_next.rdat[wdtc_pkg::CLEAR_BIT] = state_reg.counter_clear;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= '0;
         state_reg.interval_select <= wdtc_pkg::INTERVAL_SELECT_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign wb_ack_out = state_reg.ack;
   assign wb_dat_out = state_reg.rdat;
   assign timeout_irq_out = state_reg.irq;
   assign wakeup_req_out = state_reg.wake;
   assign chip_reset_out = state_reg.chip_reset;

   // Checks

   sequence s_locked_write;
      wr && !unlocked && wb_sel_in[0];
   endsequence

   sequence s_reset_start;
      $rose(chip_reset_out);
   endsequence

   property p_ack_pulse;
      @(posedge clk_in) disable iff (!rst_n_in)
      wb_ack_out |=> !wb_ack_out;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

   property p_locked;
      @(posedge clk_in) disable iff (!rst_n_in)
      s_locked_write |=> $stable(state_reg.watchdog_enable_bit) && $stable(state_reg.chip_reset_enable);
   endproperty
   a_locked: assert property (p_locked) else $error("protected bit changed while locked");

   property p_debug_hold;
      @(posedge clk_in) disable iff (!rst_n_in)
      debugger_ack_in && !state_reg.debug_ack_ignore && !state_reg.counter_clear
         && state_reg.watchdog_enable_bit |=> $stable(count);
   endproperty
   a_debug_hold: assert property (p_debug_hold) else $error("counter moved in debug");

   property p_disabled;
      @(posedge clk_in) disable iff (!rst_n_in)
      !state_reg.watchdog_enable_bit ##1 !state_reg.watchdog_enable_bit |-> count == '0;
   endproperty
   a_disabled: assert property (p_disabled) else $error("counter not zero when off");

   property p_irq_gate;
      @(posedge clk_in) disable iff (!rst_n_in)
      timeout_irq_out |-> state_reg.timeout_irq_enable && state_reg.timeout_irq_flag;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

   property p_wake_src;
      @(posedge clk_in) disable iff (!rst_n_in)
      wakeup_req_out |-> $past(low_speed_rc_osc_sel_in) && $past(state_reg.wakeup_enable)
         && state_reg.wakeup_flag;
   endproperty
   a_wake_src: assert property (p_wake_src) else $error("wake-up not allowed");

   property p_reset_gate;
      @(posedge clk_in) disable iff (!rst_n_in)
      s_reset_start |-> $past(state_reg.chip_reset_enable) && state_reg.chip_reset_flag;
   endproperty
   a_reset_gate: assert property (p_reset_gate) else $error("chip reset not enabled");

   property p_reset_hold;
      @(posedge clk_in) disable iff (!rst_n_in)
      s_reset_start |-> chip_reset_out [*8] ##0 state_reg.hold_cnt != 6'h00;
   endproperty
   a_reset_hold: assert property (p_reset_hold) else $error("chip reset too short");

   property p_clear_self;
      @(posedge clk_in) disable iff (!rst_n_in)
      state_reg.counter_clear |=> !state_reg.counter_clear && count == '0;
   endproperty
   a_clear_self: assert property (p_clear_self) else $error("clear did not act");

   property p_irq_set;
      @(posedge clk_in) disable iff (!rst_n_in)
      $rose(state_reg.timeout_irq_flag)
         |-> $past(timeout) && $past(state_reg.timeout_irq_enable);
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("irq flag without timeout");

   // A bus write in the same cycle may drop the enable, so it is left out
   property p_irq_raise;
      @(posedge clk_in) disable iff (!rst_n_in)
      timeout && state_reg.timeout_irq_enable && state_reg.watchdog_enable_bit
         && !state_reg.counter_clear && !wr |=> timeout_irq_out;
   endproperty
   a_irq_raise: assert property (p_irq_raise) else $error("timeout raised no irq");

   property p_wake_raise;
      @(posedge clk_in) disable iff (!rst_n_in)
      timeout && state_reg.wakeup_enable && power_down_in && low_speed_rc_osc_sel_in
         && state_reg.watchdog_enable_bit && !state_reg.counter_clear |=> wakeup_req_out;
   endproperty
   a_wake_raise: assert property (p_wake_raise) else $error("timeout gave no wake-up");

   property p_wake_flag;
      @(posedge clk_in) disable iff (!rst_n_in)
      $rose(state_reg.wakeup_flag) |-> wakeup_req_out;
   endproperty
   a_wake_flag: assert property (p_wake_flag) else $error("wake-up flag without wake-up");

   property p_reset_flag;
      @(posedge clk_in) disable iff (!rst_n_in)
      $rose(state_reg.chip_reset_flag) |-> $past(state_reg.chip_reset_enable) && $rose(chip_reset_out);
   endproperty
   a_reset_flag: assert property (p_reset_flag) else $error("reset flag not gated");

   property p_delay_start;
      @(posedge clk_in) disable iff (!rst_n_in)
      $rose(state_reg.dly_act) |-> $past(timeout) && state_reg.dly_cnt == 10'h000;
   endproperty
   a_delay_start: assert property (p_delay_start) else $error("delay began without timeout");

   property p_reset_end;
      @(posedge clk_in) disable iff (!rst_n_in)
      $fell(chip_reset_out) |-> $past(state_reg.hold_cnt) == 6'h01;
   endproperty
   a_reset_end: assert property (p_reset_end) else $error("chip reset ended early");

   property p_count_step;
      @(posedge clk_in) disable iff (!rst_n_in)
      run && tick && !state_reg.counter_clear |=> count == $past(count) + 18'h00001;
   endproperty
   a_count_step: assert property (p_count_step) else $error("counter missed a tick");

endmodule

// *** hw/wdtc_unlock.sv ***
module wdtc_unlock (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic unlock_wr_in,
   input wire logic [7:0] unlock_data_in,
   output logic unlocked_out
);

   typedef enum logic [1:0] {LOCKED, GOT_FIRST, GOT_SECOND, OPEN} wdtc_unlock_e;

   typedef struct packed {
      wdtc_unlock_e st;
   } wdtc_unlock_s;

   wdtc_unlock_s state_reg;
   wdtc_unlock_s state_next;

   // Any write that breaks the sequence locks again
   always_comb begin
      state_next = state_reg;
      if (unlock_wr_in) begin
         state_next.st = LOCKED;
         unique case (state_reg.st)
            LOCKED, OPEN: begin
               if (unlock_data_in == wdtc_pkg::UNLOCK_BYTE_1) state_next.st = GOT_FIRST;
            end
            GOT_FIRST: begin
               if (unlock_data_in == wdtc_pkg::UNLOCK_BYTE_2) state_next.st = GOT_SECOND;
            end
            GOT_SECOND: begin
               if (unlock_data_in == wdtc_pkg::UNLOCK_BYTE_3) state_next.st = OPEN;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= '{st: LOCKED};
      end else begin
         state_reg <= state_next;
      end
   end

   assign unlocked_out = (state_reg.st == OPEN);

endmodule

// *** verification/wdtc_testbench.sv ***
module testbench;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000;
   logic [31:0] rdat;
   logic ack;
   logic wd_clk = 1'b0;
   logic dbg_ack = 1'b0;
   logic rc_sel = 1'b0;
   logic pwr_down = 1'b0;
   logic ul_wr = 1'b0;
   logic [7:0] ul_dat = 8'h00;
   logic irq;
   logic wake;
   logic chip_rst;
   int err_total = 0;
   int checked = 0;
   int wake_cnt = 0;

   wdtc_top wdtc_top_inst (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .wb_cyc_in(cyc),
      .wb_stb_in(stb),
      .wb_we_in(we),
      .wb_adr_in(adr),
      .wb_sel_in(sel),
      .wb_dat_in(dat),
      .wb_dat_out(rdat),
      .wb_ack_out(ack),
      .watchdog_clock_in(wd_clk),
      .debugger_ack_in(dbg_ack),
      .low_speed_rc_osc_sel_in(rc_sel),
      .power_down_in(pwr_down),
      .register_unlock_port_wr_in(ul_wr),
      .register_unlock_port_data_in(ul_dat),
      .timeout_irq_out(irq),
      .wakeup_req_out(wake),
      .chip_reset_out(chip_rst)
   );

   always #25 clk_in = ~clk_in;

   // Wake requests are single-cycle pulses, so they are counted as they pass
   always @(posedge clk_in) begin
      if (wake === 1'b1) begin
         wake_cnt++;
      end
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
      end
   endtask

   // One classic cycle; read data is taken at the edge where ack is seen
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_in);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      dat <= d;
      do begin
         @(posedge clk_in);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 20) begin
         err_total++;
         $display("[FAIL] %0t bus cycle never acknowledged", $time);
         give_verdict();
      end
   endtask

   task automatic wr(input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, 8'h00, d, q);
   endtask

   task automatic rd(output logic [31:0] q);
      wb(1'b0, 8'h00, 32'h0000_0000, q);
   endtask

   task automatic tick(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_in);
         wd_clk <= 1'b1;
         @(posedge clk_in);
         wd_clk <= 1'b0;
      end
      repeat (4) @(posedge clk_in);
   endtask

   task automatic unlock;
      @(posedge clk_in);
      ul_wr <= 1'b1;
      ul_dat <= 8'h59;
      @(posedge clk_in);
      ul_dat <= 8'h16;
      @(posedge clk_in);
      ul_dat <= 8'h88;
      @(posedge clk_in);
      ul_wr <= 1'b0;
   endtask

   task automatic t_reset_and_lock;
      logic [31:0] q;
      rd(q);
      chk_word(q, 32'h0000_0700);
      wb(1'b1, 8'h04, 32'hffff_ffff, q);
      wb(1'b0, 8'h04, 32'h0000_0000, q);
      chk_word(q, 32'h0000_0000);
      wr(32'h8000_00c3);
      rd(q);
      chk_word(q, 32'h0000_0700);
      chk_bit(irq | wake | chip_rst, 1'b0);
   endtask

   task automatic t_irq_and_reset;
      logic [31:0] q;
      unlock();
      wr(32'h0000_00c2);
      rd(q);
      chk_word(q, 32'h0000_00c2);
      tick(15);
      chk_bit(irq, 1'b0);
      tick(1);
      chk_bit(irq, 1'b1);
      wr(32'h0000_00c2);
      rd(q);
      chk_word(q & 32'h0000_0008, 32'h0000_0008);
      wr(32'h0000_00ca);
      rd(q);
      chk_word(q, 32'h0000_00c2);
      tick(1022);
      chk_bit(chip_rst, 1'b0);
      tick(2);
      chk_bit(chip_rst, 1'b1);
      rd(q);
      chk_word(q & 32'h0000_0004, 32'h0000_0004);
      tick(61);
      chk_bit(chip_rst, 1'b1);
      tick(2);
      chk_bit(chip_rst, 1'b0);
      rd(q);
      chk_word(q & 32'h0000_0004, 32'h0000_0004);
   endtask

   task automatic t_clear_and_gates;
      logic [31:0] q;
      wr(32'h0000_000c);
      rd(q);
      chk_word(q, 32'h0000_0000);
      wr(32'h0000_00c0);
      tick(10);
      wr(32'h0000_00c1);
      rd(q);
      chk_word(q, 32'h0000_00c0);
      tick(15);
      chk_bit(irq, 1'b0);
      tick(1);
      chk_bit(irq, 1'b1);
      wr(32'h0000_000c);
      wr(32'h0000_0080);
      tick(1040);
      chk_bit(irq, 1'b0);
      chk_bit(chip_rst, 1'b0);
      rd(q);
      chk_word(q, 32'h0000_0080);
   endtask

   task automatic t_debug;
      wr(32'h0000_000c);
      dbg_ack <= 1'b1;
      wr(32'h0000_00c0);
      tick(20);
      chk_bit(irq, 1'b0);
      wr(32'h0000_000c);
      wr(32'h8000_00c0);
      tick(16);
      chk_bit(irq, 1'b1);
      dbg_ack <= 1'b0;
   endtask

   task automatic t_wake;
      logic [31:0] q;
      wr(32'h0000_000c);
      pwr_down <= 1'b1;
      rc_sel <= 1'b0;
      wr(32'h0000_0090);
      tick(16);
      chk_word(32'(wake_cnt), 32'h0000_0000);
      wr(32'h0000_000c);
      rc_sel <= 1'b1;
      wr(32'h0000_0090);
      tick(16);
      chk_word(32'(wake_cnt), 32'h0000_0001);
      rd(q);
      chk_word(q & 32'h0000_0020, 32'h0000_0020);
      wr(32'h0000_0020);
      rd(q);
      chk_word(q, 32'h0000_0000);
      wr(32'h0000_0080);
      tick(16);
      chk_word(32'(wake_cnt), 32'h0000_0001);
      pwr_down <= 1'b0;
   endtask

   task automatic t_interval;
      logic [31:0] q;
      wr(32'h0000_01c1);
      tick(63);
      chk_bit(irq, 1'b0);
      tick(1);
      chk_bit(irq, 1'b1);
      // A stray unlock byte locks again; the flag must still clear
      @(posedge clk_in);
      ul_wr <= 1'b1;
      ul_dat <= 8'h00;
      @(posedge clk_in);
      ul_wr <= 1'b0;
      wr(32'h0000_0008);
      rd(q);
      chk_word(q, 32'h0000_01c0);
      chk_bit(irq, 1'b0);
   endtask

   initial begin
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      t_reset_and_lock();
      t_irq_and_reset();
      t_clear_and_gates();
      t_debug();
      t_wake();
      t_interval();
      give_verdict();
   end
endmodule
